/* File: cdp_channel_divider.sv */
// How it works
// - Channels 0 and 1 build a delay code: select bit weighs 16, nibble 8-1
// - A code up to 15 delays the first rising edge that many input cycles
// - A code of 16 or more delays by code minus 16 plus low count plus 1
// - Delay is counted in cycles of the clock feeding the channel dividers
// - With correction off the high field sets the high phase, the low field the low phase
// - Each count field holds cycles minus one
// - Channels 2 and 3 cascade two 2-to-32 stages, ratio up to 1024
// - Stage one bypass is bit 4, stage two bypass bit 5
// - Both stages bypassed passes the input clock, ratio one
// - Only stage two bypassed divides by the first stage ratio
// - No bypass divides by the product of both stage ratios
// - Duty correction is on by default; bit 0 turns it off per channel
// - Correction off with stage two active: high time is its high count plus one, times the stage one ratio
// - Correction off and both stages bypassed keeps the input duty
// - Paired outputs run differential or as A and B; differential after reset
// - Phase offsets take effect only at a sync event
// - Bypassed channel 0 or 1 divides by one, else high plus low plus 2
`timescale 1ns/1ps
`include "cdp_cfg.svh"
module cdp_channel_divider (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        syncPin,
	output logic             ch0Out,
	output logic             ch0Rise,
	output logic             ch1Out,
	output logic             ch1Rise,
	output logic             ch2OutA,
	output logic             ch2OutB,
	output logic             ch2Rise,
	output logic             ch3OutA,
	output logic             ch3OutB,
	output logic             ch3Rise
);
	import cdp_pkg::*;

	logic [7:0] ch0Count_reg;
	logic [7:0] ch0Phase_reg;
	logic [7:0] ch0Duty_reg;
	logic [7:0] ch1Count_reg;
	logic [7:0] ch1Phase_reg;
	logic [7:0] ch1Duty_reg;
	logic [7:0] ch2Stage1_reg;
	logic [7:0] ch2Stage2_reg;
	logic [7:0] ch2Bypass_reg;
	logic [7:0] ch2Duty_reg;
	logic [7:0] ch3Stage1_reg;
	logic [7:0] ch3Stage2_reg;
	logic [7:0] ch3Bypass_reg;
	logic [7:0] ch3Duty_reg;
	logic [7:0] outMode_reg;
	logic       synced_reg;
	logic       kick_reg;
	logic       syncMeta_reg;
	logic       syncSafe_reg;
	logic       syncLast_reg;
	logic       loadNow;
	logic       loadLate_reg;
	logic [9:0] regIndex;
	logic       hit;
	logic [7:0] readValue;
	logic       ch2S1Out;
	logic       ch2S1Rise;
	logic       ch3S1Out;
	logic       ch3S1Rise;
	logic       ch2Level;
	logic       ch2Edge;
	logic       ch3Level;
	logic       ch3Edge;

	function automatic cdp_nibble_type highOf(input logic [7:0] r);
		return r[`CDP_HIGH_LSB +: `CDP_NIBBLE_W];
	endfunction : highOf

	function automatic cdp_nibble_type lowOf(input logic [7:0] r);
		return r[`CDP_LOW_LSB +: `CDP_NIBBLE_W];
	endfunction : lowOf

	// Turns the phase fields and low count into whole input cycles
	function automatic logic [4:0] delayOf(
		input logic [7:0] phase,
		input logic [7:0] counts
	);
		logic [5:0] code;
		code = {1'b0, phase[`CDP_MSB_SEL_BIT],
			phase[`CDP_COARSE_LSB +: `CDP_NIBBLE_W]};
		if (code < `CDP_CODE_SPLIT) begin
			return code[4:0];
		end
		return 5'(code - `CDP_CODE_SPLIT + 6'(lowOf(counts)) + 6'h01);
	endfunction : delayOf

	// Sync pin crosses in through two flops before the edge detector
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			syncMeta_reg <= 1'b0;
			syncSafe_reg <= 1'b0;
			syncLast_reg <= 1'b0;
		end else begin
			syncMeta_reg <= syncPin;
			syncSafe_reg <= syncMeta_reg;
			syncLast_reg <= syncSafe_reg;
		end
	end

	// One restart right after reset so outputs run without a pin event
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			kick_reg   <= 1'b1;
			synced_reg <= 1'b0;
		end else begin
			kick_reg <= 1'b0;
			if (loadNow) begin
				synced_reg <= 1'b1;
			end
		end
	end

	assign loadNow = kick_reg || (syncSafe_reg && !syncLast_reg);

	// Stage two restarts a cycle after stage one: the pulse it counts is
	// registered, so a same-cycle restart would count the first rise
	// twice and cut the first output period short
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			loadLate_reg <= 1'b0;
		end else begin
			loadLate_reg <= loadNow;
		end
	end

	// APB slave: zero wait states, read data captured in the setup cycle
	assign regIndex = paddr[11:2];
	assign pready   = 1'b1;

	always_comb begin
		hit       = 1'b1;
		readValue = 8'h00;
		unique case (regIndex)
			`CDP_IDX_CH0_COUNT:  readValue = ch0Count_reg;
			`CDP_IDX_CH0_PHASE:  readValue = ch0Phase_reg;
			`CDP_IDX_CH0_DUTY:   readValue = ch0Duty_reg;
			`CDP_IDX_CH1_COUNT:  readValue = ch1Count_reg;
			`CDP_IDX_CH1_PHASE:  readValue = ch1Phase_reg;
			`CDP_IDX_CH1_DUTY:   readValue = ch1Duty_reg;
			`CDP_IDX_CH2_STAGE1: readValue = ch2Stage1_reg;
			`CDP_IDX_CH2_STAGE2: readValue = ch2Stage2_reg;
			`CDP_IDX_CH2_BYPASS: readValue = ch2Bypass_reg;
			`CDP_IDX_CH2_DUTY:   readValue = ch2Duty_reg;
			`CDP_IDX_CH3_STAGE1: readValue = ch3Stage1_reg;
			`CDP_IDX_CH3_STAGE2: readValue = ch3Stage2_reg;
			`CDP_IDX_CH3_BYPASS: readValue = ch3Bypass_reg;
			`CDP_IDX_CH3_DUTY:   readValue = ch3Duty_reg;
			`CDP_IDX_OUT_MODE:   readValue = outMode_reg;
			`CDP_IDX_STATUS:     readValue = {3'h0, synced_reg, ch3Level,
				ch2Level, ch1Out, ch0Out};
			default:             hit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, readValue};
			pslverr <= !hit;
		end
	end

	// Writes land at the access edge; status is read only
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ch0Count_reg  <= `CDP_RST_COUNT;
			ch0Phase_reg  <= `CDP_RST_PHASE;
			ch0Duty_reg   <= `CDP_RST_DUTY;
			ch1Count_reg  <= `CDP_RST_COUNT;
			ch1Phase_reg  <= `CDP_RST_PHASE;
			ch1Duty_reg   <= `CDP_RST_DUTY;
			ch2Stage1_reg <= `CDP_RST_COUNT;
			ch2Stage2_reg <= `CDP_RST_COUNT;
			ch2Bypass_reg <= `CDP_RST_BYPASS;
			ch2Duty_reg   <= `CDP_RST_DUTY;
			ch3Stage1_reg <= `CDP_RST_COUNT;
			ch3Stage2_reg <= `CDP_RST_COUNT;
			ch3Bypass_reg <= `CDP_RST_BYPASS;
			ch3Duty_reg   <= `CDP_RST_DUTY;
			outMode_reg   <= `CDP_RST_MODE;
		end else if (psel && penable && pwrite) begin
			unique case (regIndex)
				`CDP_IDX_CH0_COUNT:  ch0Count_reg  <= pwdata[7:0];
				`CDP_IDX_CH0_PHASE:  ch0Phase_reg  <= pwdata[7:0];
				`CDP_IDX_CH0_DUTY:   ch0Duty_reg   <= pwdata[7:0];
				`CDP_IDX_CH1_COUNT:  ch1Count_reg  <= pwdata[7:0];
				`CDP_IDX_CH1_PHASE:  ch1Phase_reg  <= pwdata[7:0];
				`CDP_IDX_CH1_DUTY:   ch1Duty_reg   <= pwdata[7:0];
				`CDP_IDX_CH2_STAGE1: ch2Stage1_reg <= pwdata[7:0];
				`CDP_IDX_CH2_STAGE2: ch2Stage2_reg <= pwdata[7:0];
				`CDP_IDX_CH2_BYPASS: ch2Bypass_reg <= pwdata[7:0];
				`CDP_IDX_CH2_DUTY:   ch2Duty_reg   <= pwdata[7:0];
				`CDP_IDX_CH3_STAGE1: ch3Stage1_reg <= pwdata[7:0];
				`CDP_IDX_CH3_STAGE2: ch3Stage2_reg <= pwdata[7:0];
				`CDP_IDX_CH3_BYPASS: ch3Bypass_reg <= pwdata[7:0];
				`CDP_IDX_CH3_DUTY:   ch3Duty_reg   <= pwdata[7:0];
				`CDP_IDX_OUT_MODE:   outMode_reg   <= pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// The core clock stands for the channel input clock: a rise every cycle
	cdp_stage ch0Div (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.loadNow  (loadNow),
		.inLevel  (1'b1),
		.inRise   (1'b1),
		.highCnt  (highOf(ch0Count_reg)),
		.lowCnt   (lowOf(ch0Count_reg)),
		.delayCnt (delayOf(ch0Phase_reg, ch0Count_reg)),
		.bypass   (ch0Phase_reg[`CDP_BYPASS01_BIT]),
		.dccOn    (!ch0Duty_reg[`CDP_DUTY_OFF_BIT]),
		.outLevel (ch0Out),
		.outRise  (ch0Rise)
	);

	cdp_stage ch1Div (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.loadNow  (loadNow),
		.inLevel  (1'b1),
		.inRise   (1'b1),
		.highCnt  (highOf(ch1Count_reg)),
		.lowCnt   (lowOf(ch1Count_reg)),
		.delayCnt (delayOf(ch1Phase_reg, ch1Count_reg)),
		.bypass   (ch1Phase_reg[`CDP_BYPASS01_BIT]),
		.dccOn    (!ch1Duty_reg[`CDP_DUTY_OFF_BIT]),
		.outLevel (ch1Out),
		.outRise  (ch1Rise)
	);

	// Second stage counts rising edges of the first: ratios multiply
	cdp_stage ch2First (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.loadNow  (loadNow),
		.inLevel  (1'b1),
		.inRise   (1'b1),
		.highCnt  (highOf(ch2Stage1_reg)),
		.lowCnt   (lowOf(ch2Stage1_reg)),
		.delayCnt (5'h00),
		.bypass   (ch2Bypass_reg[`CDP_BYPASS_S1_BIT]),
		.dccOn    (!ch2Duty_reg[`CDP_DUTY_OFF_BIT]),
		.outLevel (ch2S1Out),
		.outRise  (ch2S1Rise)
	);

	// Late restart keeps stage two in step with the registered pulse
	cdp_stage ch2Second (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.loadNow  (loadLate_reg),
		.inLevel  (ch2S1Out),
		.inRise   (ch2S1Rise),
		.highCnt  (highOf(ch2Stage2_reg)),
		.lowCnt   (lowOf(ch2Stage2_reg)),
		.delayCnt (5'h00),
		.bypass   (ch2Bypass_reg[`CDP_BYPASS_S2_BIT]),
		.dccOn    (!ch2Duty_reg[`CDP_DUTY_OFF_BIT]),
		.outLevel (ch2Level),
		.outRise  (ch2Edge)
	);

	cdp_stage ch3First (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.loadNow  (loadNow),
		.inLevel  (1'b1),
		.inRise   (1'b1),
		.highCnt  (highOf(ch3Stage1_reg)),
		.lowCnt   (lowOf(ch3Stage1_reg)),
		.delayCnt (5'h00),
		.bypass   (ch3Bypass_reg[`CDP_BYPASS_S1_BIT]),
		.dccOn    (!ch3Duty_reg[`CDP_DUTY_OFF_BIT]),
		.outLevel (ch3S1Out),
		.outRise  (ch3S1Rise)
	);

	// Same late restart as channel 2
	cdp_stage ch3Second (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.loadNow  (loadLate_reg),
		.inLevel  (ch3S1Out),
		.inRise   (ch3S1Rise),
		.highCnt  (highOf(ch3Stage2_reg)),
		.lowCnt   (lowOf(ch3Stage2_reg)),
		.delayCnt (5'h00),
		.bypass   (ch3Bypass_reg[`CDP_BYPASS_S2_BIT]),
		.dccOn    (!ch3Duty_reg[`CDP_DUTY_OFF_BIT]),
		.outLevel (ch3Level),
		.outRise  (ch3Edge)
	);

	// Differential: B is the complement; single ended: B gated by its enable
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ch2OutA <= 1'b0;
			ch2OutB <= 1'b0;
			ch2Rise <= 1'b0;
			ch3OutA <= 1'b0;
			ch3OutB <= 1'b0;
			ch3Rise <= 1'b0;
		end else begin
			ch2OutA <= ch2Level;
			ch2Rise <= ch2Edge;
			ch2OutB <= outMode_reg[`CDP_MODE_CH2_SE_BIT] ?
				(ch2Level && outMode_reg[`CDP_MODE_CH2_B_BIT]) : !ch2Level;
			ch3OutA <= ch3Level;
			ch3Rise <= ch3Edge;
			ch3OutB <= outMode_reg[`CDP_MODE_CH3_SE_BIT] ?
				(ch3Level && outMode_reg[`CDP_MODE_CH3_B_BIT]) : !ch3Level;
		end
	end

endmodule : cdp_channel_divider

/* File: cdp_cfg.svh */
`ifndef CDP_CFG_SVH
`define CDP_CFG_SVH

// Register indices; byte address is four times the index
`define CDP_IDX_CH0_COUNT   10'h190
`define CDP_IDX_CH0_PHASE   10'h191
`define CDP_IDX_CH0_DUTY    10'h192
`define CDP_IDX_CH1_COUNT   10'h196
`define CDP_IDX_CH1_PHASE   10'h197
`define CDP_IDX_CH1_DUTY    10'h198
`define CDP_IDX_CH2_STAGE1  10'h199
`define CDP_IDX_CH2_STAGE2  10'h19b
`define CDP_IDX_CH2_BYPASS  10'h19c
`define CDP_IDX_CH2_DUTY    10'h19d
`define CDP_IDX_CH3_STAGE1  10'h19e
`define CDP_IDX_CH3_STAGE2  10'h1a0
`define CDP_IDX_CH3_BYPASS  10'h1a1
`define CDP_IDX_CH3_DUTY    10'h1a2
`define CDP_IDX_OUT_MODE    10'h1f0
`define CDP_IDX_STATUS      10'h1f1

// Field positions
`define CDP_HIGH_LSB        0
`define CDP_LOW_LSB         4
`define CDP_NIBBLE_W        4
`define CDP_COARSE_LSB      0
`define CDP_MSB_SEL_BIT     4
`define CDP_BYPASS01_BIT    7
`define CDP_BYPASS_S1_BIT   4
`define CDP_BYPASS_S2_BIT   5
`define CDP_DUTY_OFF_BIT    0
`define CDP_MODE_CH2_SE_BIT 0
`define CDP_MODE_CH3_SE_BIT 1
`define CDP_MODE_CH2_B_BIT  2
`define CDP_MODE_CH3_B_BIT  3

// Reset values
`define CDP_RST_COUNT       8'h00
`define CDP_RST_PHASE       8'h00
`define CDP_RST_DUTY        8'h00
`define CDP_RST_BYPASS      8'h00
`define CDP_RST_MODE        8'h00

// Delay code threshold where the low count joins the offset
`define CDP_CODE_SPLIT      6'h10

`endif

/* File: cdp_pkg.sv */
package cdp_pkg;

	typedef enum logic [1:0] {
		cdpIdle,
		cdpDelay,
		cdpHigh,
		cdpLow
	} cdp_phase_type;

	typedef logic [3:0] cdp_nibble_type;

endpackage : cdp_pkg

/* File: cdp_stage.sv */
`timescale 1ns/1ps
module cdp_stage (
	input  wire logic                   core_clk,
	input  wire logic                   sys_rst,
	input  wire logic                   loadNow,
	input  wire logic                   inLevel,
	input  wire logic                   inRise,
	input  wire cdp_pkg::cdp_nibble_type highCnt,
	input  wire cdp_pkg::cdp_nibble_type lowCnt,
	input  wire logic [4:0]             delayCnt,
	input  wire logic                   bypass,
	input  wire logic                   dccOn,
	output logic                        outLevel,
	output logic                        outRise
);
	import cdp_pkg::*;

	cdp_nibble_type hiCnt_reg;
	cdp_nibble_type loCnt_reg;
	logic           byp_reg;
	logic           dcc_reg;
	cdp_phase_type  phase_reg;
	logic [4:0]     cnt_reg;
	logic           bypassNow;
	logic           enterHigh;
	logic           leaveHigh;

	// Phase lengths; correction splits the whole ratio, high gets the floor
	function automatic logic [4:0] phaseLen(
		input cdp_nibble_type n,
		input cdp_nibble_type m,
		input logic           dcc,
		input logic           wantHigh
	);
		logic [5:0] ratio;
		logic [4:0] hi;
		ratio = 6'(n) + 6'(m) + 6'h02;
		hi = dcc ? ratio[5:1] : 5'(n) + 5'h01;
		return wantHigh ? hi : 5'(ratio - 6'(hi));
	endfunction : phaseLen

	assign bypassNow = loadNow ? bypass : byp_reg;
	assign enterHigh = loadNow ? (delayCnt == 5'h00) :
		(inRise && cnt_reg == 5'h00 &&
		(phase_reg == cdpDelay || phase_reg == cdpLow));
	assign leaveHigh = !loadNow && inRise && cnt_reg == 5'h00 &&
		phase_reg == cdpHigh;

	// Settings only reach the counters at a sync event
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hiCnt_reg <= 4'h0;
			loCnt_reg <= 4'h0;
			byp_reg   <= 1'b0;
			dcc_reg   <= 1'b1;
		end else if (loadNow) begin
			hiCnt_reg <= highCnt;
			loCnt_reg <= lowCnt;
			byp_reg   <= bypass;
			dcc_reg   <= dccOn;
		end
	end

	// Counter advances once per rising edge of this stage's input
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			phase_reg <= cdpIdle;
			cnt_reg   <= 5'h00;
		end else if (loadNow) begin
			if (delayCnt == 5'h00) begin
				phase_reg <= cdpHigh;
				cnt_reg   <= phaseLen(highCnt, lowCnt, dccOn, 1'b1) - 5'h01;
			end else begin
				phase_reg <= cdpDelay;
				cnt_reg   <= delayCnt - 5'h01;
			end
		end else if (inRise && phase_reg != cdpIdle) begin
			if (cnt_reg != 5'h00) begin
				cnt_reg <= cnt_reg - 5'h01;
			end else begin
				unique case (phase_reg)
					cdpDelay, cdpLow: begin
						phase_reg <= cdpHigh;
						cnt_reg   <= phaseLen(hiCnt_reg, loCnt_reg, dcc_reg,
							1'b1) - 5'h01;
					end
					cdpHigh: begin
						phase_reg <= cdpLow;
						cnt_reg   <= phaseLen(hiCnt_reg, loCnt_reg, dcc_reg,
							1'b0) - 5'h01;
					end
					cdpIdle: begin
						phase_reg <= cdpIdle;
					end
				endcase
			end
		end
	end

	// Registered output; a bypassed stage repeats its input unchanged
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			outLevel <= 1'b0;
			outRise  <= 1'b0;
		end else if (bypassNow) begin
			outLevel <= inLevel;
			outRise  <= inRise;
		end else begin
			outRise <= enterHigh;
			if (enterHigh) begin
				outLevel <= 1'b1;
			end else if (leaveHigh || loadNow) begin
				outLevel <= 1'b0;
			end
		end
	end

endmodule : cdp_stage

/* File: cdp_monitor.sv */
`timescale 1ns/1ps
module cdp_monitor (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	input  wire logic        syncPin,
	input  wire logic        ch0Out,
	input  wire logic        ch0Rise,
	input  wire logic        ch1Out,
	input  wire logic        ch1Rise,
	input  wire logic        ch2OutA,
	input  wire logic        ch2OutB,
	input  wire logic        ch2Rise,
	input  wire logic        ch3OutA,
	input  wire logic        ch3OutB,
	input  wire logic        ch3Rise
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// Window covers sync flops plus the longest coarse delay
	sequence syncRise;
		$rose(syncPin);
	endsequence

	a_ready_access:
		assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	a_err_setup:
		assert property ($rose(pslverr) |-> $past(psel && !penable))
		else $error("pslverr rose without a setup cycle");
	a_rdata_upper:
		assert property (prdata[31:8] == 24'h0)
		else $error("prdata upper bits not zero");
	a_rdata_hold:
		assert property (psel && penable |=> $stable(prdata))
		else $error("prdata changed outside a setup cycle");
	a_reset_quiet:
		assert property (disable iff (1'b0) sys_rst |=> !ch0Out && !ch1Out
			&& !ch2OutA && !ch2OutB && !ch3OutA && !ch3OutB)
		else $error("output active after reset");
	a_ch0_edge:
		assert property ($rose(ch0Out) |-> ch0Rise)
		else $error("channel 0 rose without pulse");
	a_ch1_edge:
		assert property ($rose(ch1Out) |-> ch1Rise)
		else $error("channel 1 rose without pulse");
	a_ch2_pulse:
		assert property (ch2Rise |-> ch2OutA)
		else $error("channel 2 pulse with low level");
	a_ch3_pulse:
		assert property (ch3Rise |-> ch3OutA)
		else $error("channel 3 pulse with low level");
	a_sync_ch0:
		assert property (syncRise |-> ##[3:45] ch0Rise)
		else $error("channel 0 did not restart");
	a_sync_ch2:
		assert property (syncRise |-> ##[3:45] ch2Rise)
		else $error("channel 2 did not restart");
endmodule : cdp_monitor

/* File: test_channel_divider_phase_offset.sv */
`timescale 1ns/1ps
`include "cdp_cfg.svh"
module test_channel_divider_phase_offset;
	logic        core_clk, sys_rst, psel, penable, pwrite, syncPin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, err, ch0Out, ch0Rise, ch1Out, ch1Rise;
	logic        ch2OutA, ch2OutB, ch2Rise, ch3OutA, ch3OutB, ch3Rise;
	logic [7:0]  v, s1, s2;
	logic [4:0]  c;
	logic [9:0]  base;
	int          fails, total_checks, cycleCount, seed, per, hi, k, prev;
	logic [9:0]  regIdx [12] = '{`CDP_IDX_CH0_COUNT, `CDP_IDX_CH0_PHASE,
		`CDP_IDX_CH1_COUNT, `CDP_IDX_CH1_PHASE, `CDP_IDX_CH2_STAGE1,
		`CDP_IDX_CH2_STAGE2, `CDP_IDX_CH2_BYPASS, `CDP_IDX_CH2_DUTY,
		`CDP_IDX_CH3_STAGE1, `CDP_IDX_CH3_STAGE2, `CDP_IDX_CH3_BYPASS,
		`CDP_IDX_CH3_DUTY};
	logic [4:0]  codes [5] = '{5'h00, 5'h01, 5'h0f, 5'h10, 5'h1f};
	// Stage one is never bypassed alone
	logic [7:0]  bypTab [3] = '{8'h30, 8'h20, 8'h00};
	logic [7:0]  modeTab [3] = '{8'h03, 8'h0f, 8'h00};

	cdp_channel_divider u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .syncPin(syncPin), .ch0Out(ch0Out),
		.ch0Rise(ch0Rise), .ch1Out(ch1Out), .ch1Rise(ch1Rise),
		.ch2OutA(ch2OutA), .ch2OutB(ch2OutB), .ch2Rise(ch2Rise),
		.ch3OutA(ch3OutA), .ch3OutB(ch3OutB), .ch3Rise(ch3Rise));

	always #4 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycleCount++;
		if (cycleCount > 30000) begin
			fails++;
			wrap_up();
		end
	end

	function automatic int ratioOf(input logic [7:0] cnt);
		return int'(cnt[3:0]) + int'(cnt[7:4]) + 2;
	endfunction : ratioOf

	function automatic int delayOf(input logic [4:0] code, input int m);
		return code < 5'h10 ? int'(code) : int'(code) - 16 + m + 1;
	endfunction : delayOf

	function automatic logic expB(input logic se, en, a);
		return se ? a & en : ~a;
	endfunction : expB

	function automatic logic riseOf(input int ch);
		return ch == 0 ? ch0Rise : ch == 1 ? ch1Rise : ch == 2 ? ch2Rise
			: ch3Rise;
	endfunction : riseOf

	function automatic logic levOf(input int ch);
		return ch == 0 ? ch0Out : ch == 1 ? ch1Out : ch == 2 ? ch2OutA
			: ch3OutA;
	endfunction : levOf

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [9:0] idx,
		input logic [7:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic resync();
		@(posedge core_clk);
		syncPin <= 1'b1;
		repeat (4) @(posedge core_clk);
		syncPin <= 1'b0;
		repeat (60) @(posedge core_clk);
	endtask : resync

	// Period and high time, counted between two rise pulses
	task automatic measure(input int ch);
		k = 0;
		@(negedge core_clk);
		while (riseOf(ch) !== 1'b1 && k < 3000) begin
			@(negedge core_clk);
			k++;
		end
		per = 0;
		hi = 1;
		do begin
			@(negedge core_clk);
			per++;
			if (riseOf(ch) !== 1'b1 && levOf(ch) === 1'b1)
				hi++;
		end while (riseOf(ch) !== 1'b1 && per < 3000);
	endtask : measure

	// Channel 1 runs with no offset and serves as the reference
	task automatic offset();
		k = 0;
		@(negedge core_clk);
		while (ch1Rise !== 1'b1 && k < 100) begin
			@(negedge core_clk);
			k++;
		end
		k = 0;
		while (ch0Rise !== 1'b1 && k < 100) begin
			@(negedge core_clk);
			k++;
		end
	endtask : offset

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	initial begin
		seed = 50823;
		core_clk = 1'b0;
		sys_rst = 1'b1;
		{psel, penable, pwrite, syncPin} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		{fails, total_checks, cycleCount} = '0;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		foreach (regIdx[i]) begin
			apb(1'b0, regIdx[i], 8'h00);
			check(rd, 32'h0);
			v = 8'($random(seed));
			apb(1'b1, regIdx[i], v);
			apb(1'b0, regIdx[i], 8'h00);
			check(rd, {24'h0, v});
			apb(1'b1, regIdx[i], 8'h00);
		end
		apb(1'b0, 10'h000, 8'h00);
		check(rd, 32'h0);
		check(err, 1'b1);
		$display("register test done");
		for (int i = 0; i < 6; i++) begin
			v = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed));
			if (!i[0])
				v = {4'(v[2:0]) + 4'(i[1]), 1'b0, v[2:0]};
			apb(1'b1, `CDP_IDX_CH0_COUNT, v);
			apb(1'b1, `CDP_IDX_CH0_DUTY, {7'h0, i[0]});
			resync();
			measure(0);
			check(per, ratioOf(v));
			check(hi, i[0] ? int'(v[3:0]) + 1 : ratioOf(v) / 2);
			apb(1'b1, `CDP_IDX_CH0_COUNT, v ^ 8'h01);
			measure(0);
			check(per, ratioOf(v));
		end
		apb(1'b1, `CDP_IDX_CH0_PHASE, 8'h80);
		apb(1'b1, `CDP_IDX_CH1_PHASE, 8'h80);
		resync();
		measure(0);
		check(per, 1);
		measure(1);
		check(per, 1);
		$display("channel 0 ratio test done");
		// High count 15 keeps every delay below one period
		v = {4'($random(seed)), 4'hf};
		apb(1'b1, `CDP_IDX_CH0_COUNT, v);
		apb(1'b1, `CDP_IDX_CH1_COUNT, v);
		apb(1'b1, `CDP_IDX_CH0_PHASE, 8'h00);
		apb(1'b1, `CDP_IDX_CH1_PHASE, 8'h00);
		resync();
		prev = 0;
		for (int i = 0; i < 8; i++) begin
			c = i < 5 ? codes[i] : 5'($random(seed));
			apb(1'b1, `CDP_IDX_CH0_PHASE, {3'h0, c});
			offset();
			check(k, prev);
			resync();
			offset();
			prev = delayOf(c, int'(v[7:4]));
			check(k, prev);
		end
		$display("phase test done");
		for (int ch = 2; ch < 4; ch++) begin
			base = ch == 2 ? `CDP_IDX_CH2_STAGE1 : `CDP_IDX_CH3_STAGE1;
			for (int j = 0; j < 3; j++) begin
				s1 = 8'($random(seed)) & 8'h33;
				s2 = 8'($random(seed)) & 8'h33;
				apb(1'b1, base, s1);
				apb(1'b1, base + 10'h2, s2);
				apb(1'b1, base + 10'h3, bypTab[j]);
				apb(1'b1, base + 10'h4, 8'h01);
				resync();
				measure(ch);
				check(per, j == 0 ? 1 : j == 1 ? ratioOf(s1)
					: ratioOf(s1) * ratioOf(s2));
				check(hi, j == 0 ? 1 : j == 1 ? int'(s1[3:0]) + 1
					: (int'(s2[3:0]) + 1) * ratioOf(s1));
			end
		end
		$display("cascade test done");
		for (int j = 0; j < 3; j++) begin
			apb(1'b1, `CDP_IDX_OUT_MODE, modeTab[j]);
			repeat (2) @(posedge core_clk);
			repeat (40) begin
				@(negedge core_clk);
				check(ch2OutB, expB(modeTab[j][0], modeTab[j][2], ch2OutA));
				check(ch3OutB, expB(modeTab[j][1], modeTab[j][3], ch3OutA));
			end
		end
		$display("output mode test done");
		wrap_up();
	end
endmodule : test_channel_divider_phase_offset

bind cdp_channel_divider cdp_monitor u_mon (.core_clk(core_clk),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .syncPin(syncPin),
	.ch0Out(ch0Out), .ch0Rise(ch0Rise), .ch1Out(ch1Out),
	.ch1Rise(ch1Rise), .ch2OutA(ch2OutA), .ch2OutB(ch2OutB),
	.ch2Rise(ch2Rise), .ch3OutA(ch3OutA), .ch3OutB(ch3OutB),
	.ch3Rise(ch3Rise));
